/* File: verilog/ctf_pkg.sv */
package ctf_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TEST_CONTROL_ZERO = 8'h18;
  localparam logic [7:0] IDX_FIFO_LANE_FLAGS = 8'h19;
  localparam logic [7:0] IDX_DMA_HANDSHAKE_STATUS = 8'h1A;
  localparam logic [7:0] IDX_REVISION_AND_FIFO_CONTROL = 8'h1B;
  localparam int ADDR_W = 12;

  // test_control_zero fields
  localparam int BIT_BURST_DISABLE = 7;
  localparam int BIT_SNOOP_CTL_HI = 6;
  localparam int BIT_SNOOP_CTL_LO = 5;
  localparam int BIT_FIFO_PARITY = 3;
  localparam int BIT_EVEN_HOST_PARITY = 2;
  localparam int BIT_TRANSFER_TYPE = 1;
  localparam logic [7:0] CTL0_WRITE_MASK = 8'hEE;
  localparam logic [7:0] CTL0_RESET = 8'h00;

  // revision_and_fifo_control fields
  localparam int REV_LSB = 4;
  localparam int BIT_FLUSH_FIFO = 3;
  localparam int BIT_CLEAR_FIFOS = 2;
  localparam int BIT_FETCH_PIN_MODE = 1;
  localparam int BIT_SNOOP_PIN_MODE = 0;
  localparam logic [3:0] CTL3_RESET = 4'h0;
  // value is arbitrary
  localparam logic [3:0] REVISION_DEFAULT = 4'h5;

  // dma_handshake_status fields
  localparam int BIT_DIRECTION = 7;
  localparam int BIT_SIGNAL_PROCESS = 6;
  localparam int BIT_TRUE_EOP = 2;
  localparam int BIT_DATA_REQUEST = 1;
  localparam int BIT_DATA_ACK = 0;

  typedef struct packed {
    logic [3:0] lane_empty_flags;
    logic [3:0] lane_full_flags;
    logic       dma_write_direction;
    logic       signal_process_flag;
    logic       true_end_of_process;
    logic       data_request_state;
    logic       data_ack_state_n;
  } ctf_dma_status_s;

  typedef struct packed {
    logic       bus_owner;
    logic       bus_mode_one;
    logic       host_cycle_request;
    logic       transfer_start_strobe;
    logic       last_bus_cycle;
    logic       global_high_z;
    logic       fetch_cycle;
    logic       fetch_opcode_phase;
    logic       burst_conditions_met;
  } ctf_bus_state_s;

endpackage

/* File: verilog/ctf_chip_test_regs.sv */
// Operation
// RQ1: burst disable bit blocks cache-line burst requests
// RQ2: snoop bits drive snoop pins while owning
// RQ3: written parity bit tags each pushed byte
// RQ4: even mode generates even parity when driving
// RQ5: even mode inverts parity across both paths
// RQ6: odd mode keeps odd parity, no inversion
// RQ7: transfer-type pin carries inverted bit, modes 2-4
// RQ8: four lane empty flags readable
// RQ9: four lane full flags readable
// RQ10: direction bit reads one for scsi-to-host
// RQ11: signal-process mirror; read clears original flag
// RQ12: data port read latches popped byte parity
// RQ13: true end of process readable, high active
// RQ14: data request readable, high active
// RQ15: data acknowledge readable, reads one inactive
// RQ16: four-bit fixed revision code readable
// RQ17: flush moves fifo; software clears bit
// RQ18: clear fifos pulses then self-clears
// RQ19: fetch mode set: pin only on opcode
// RQ20: fetch mode clear: pin on all fetch cycles
// RQ21: snoop mode: pins always driven except high-z
// RQ22: snoop pin 0 leads bus request, ends last strobe
// RQ23: direction high means scsi-to-host flush
// RQ24: read-only writes ignored; reserved bits stable
`timescale 1ns/10ps
module ctf_chip_test_regs #(
  parameter logic [3:0] REVISION = ctf_pkg::REVISION_DEFAULT
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [ctf_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             read_data_parity,
  input  wire ctf_pkg::ctf_dma_status_s    dma_status,
  input  wire ctf_pkg::ctf_bus_state_s     bus_state,
  input  wire logic                        fifo_port_read,
  input  wire logic                        fifo_bottom_parity,
  input  wire logic                        clear_fifos_done,
  input  wire logic                        scsi_parity_in,
  input  wire logic [7:0]                  host_data_in,
  input  wire logic                        host_parity_in,
  input  wire logic [7:0]                  master_write_data,
  output logic                             host_parity_out,
  output logic                             master_write_parity,
  output logic                             scsi_parity_out,
  output logic                             host_parity_error,
  output logic                             fifo_write_parity,
  output logic                             cache_burst_request,
  output logic                             snoop_hi_out,
  output logic                             snoop_hi_oe_n,
  output logic                             snoop_lo_out,
  output logic                             snoop_lo_oe_n,
  output logic                             bus_request_out,
  output logic                             transfer_type_out,
  output logic                             transfer_type_oe_n,
  output logic                             fetch_pin_n,
  output logic                             signal_process_clear,
  output logic                             flush_fifo,
  output logic                             flush_to_memory,
  output logic                             clear_fifos
);

  function automatic logic odd_parity(input logic [7:0] d);
    odd_parity = ~(^d);
  endfunction

  logic [7:0] ctl0;
  logic [3:0] ctl3;
  logic       popped_parity;
  logic       snoop_req;

  // bus decode
  wire        in_setup = psel & ~penable;
  wire        in_access = psel & penable;
  wire [7:0]  reg_index = paddr[9:2];
  wire        word_aligned = (paddr[1:0] == 2'b00) && (paddr[ctf_pkg::ADDR_W-1:10] == '0);
  wire        hit_ctl0 = word_aligned && (reg_index == ctf_pkg::IDX_TEST_CONTROL_ZERO);
  wire        hit_flags = word_aligned && (reg_index == ctf_pkg::IDX_FIFO_LANE_FLAGS);
  wire        hit_status = word_aligned && (reg_index == ctf_pkg::IDX_DMA_HANDSHAKE_STATUS);
  wire        hit_ctl3 = word_aligned && (reg_index == ctf_pkg::IDX_REVISION_AND_FIFO_CONTROL);
  wire        hit_any = hit_ctl0 | hit_flags | hit_status | hit_ctl3;
  wire        wr_done = in_access & pwrite & hit_any;
  wire        rd_done = in_access & ~pwrite & hit_any;
  wire        wr_ctl0 = wr_done & hit_ctl0;
  wire        wr_ctl3 = wr_done & hit_ctl3;

  // read views
  wire [7:0]  view_ctl0 = ctl0;
  wire [7:0]  view_flags = {dma_status.lane_empty_flags, dma_status.lane_full_flags}; // RQ8 RQ9
  wire [7:0]  view_status = {dma_status.dma_write_direction,     // RQ10
                             dma_status.signal_process_flag,     // RQ11
                             2'b00,                              // RQ24
                             popped_parity,                      // RQ12
                             dma_status.true_end_of_process,     // RQ13
                             dma_status.data_request_state,      // RQ14
                             dma_status.data_ack_state_n};       // RQ15
  wire [7:0]  view_ctl3 = {REVISION, ctl3};                      // RQ16
  wire [7:0]  read_byte = hit_ctl0  ? view_ctl0 :
                          hit_flags ? view_flags :
                          hit_status ? view_status :
                          hit_ctl3  ? view_ctl3 : 8'h00;
  wire        even_mode = ctl0[ctf_pkg::BIT_EVEN_HOST_PARITY];

  // zero-wait slave: answer in the first access cycle
  assign pready = 1'b1;
  assign pslverr = in_access & ~hit_any;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      read_data_parity <= 1'b1;
    end
    else if (in_setup & ~pwrite)
    begin
      prdata <= {24'h00_0000, read_byte};
      read_data_parity <= odd_parity(read_byte) ^ even_mode; // RQ4 RQ6
    end
  end

  // control register zero; reserved bits stay zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctl0 <= ctf_pkg::CTL0_RESET;
    else if (wr_ctl0)
      ctl0 <= pwdata[7:0] & ctf_pkg::CTL0_WRITE_MASK;
  end

  // control register three; revision field and the read-only flag and status registers ignore writes
  logic [3:0] next_ctl3;
  always_comb
  begin
    next_ctl3 = ctl3;
    if (clear_fifos_done)
      next_ctl3[ctf_pkg::BIT_CLEAR_FIFOS] = 1'b0; // RQ18
    if (wr_ctl3)
      next_ctl3 = pwdata[3:0]; // RQ24
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctl3 <= ctf_pkg::CTL3_RESET;
    else
      ctl3 <= next_ctl3;
  end

  // parity of the byte leaving the fifo bottom
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      popped_parity <= 1'b0;
    else if (fifo_port_read)
      popped_parity <= fifo_bottom_parity; // RQ12
  end

  assign signal_process_clear = rd_done & hit_status; // RQ11
  assign fifo_write_parity = ctl0[ctf_pkg::BIT_FIFO_PARITY]; // RQ3
  assign flush_fifo = ctl3[ctf_pkg::BIT_FLUSH_FIFO]; // RQ17
  assign flush_to_memory = dma_status.dma_write_direction; // RQ23
  assign clear_fifos = ctl3[ctf_pkg::BIT_CLEAR_FIFOS]; // RQ18

  // parity sense: odd throughout unless even mode inverts at the host edge
  assign host_parity_out = scsi_parity_in ^ even_mode; // RQ5 RQ6
  assign scsi_parity_out = host_parity_in ^ even_mode; // RQ5 RQ6
  assign host_parity_error = (host_parity_in ^ even_mode) != odd_parity(host_data_in); // RQ5
  assign master_write_parity = odd_parity(master_write_data) ^ even_mode; // RQ4

  assign cache_burst_request = bus_state.burst_conditions_met
                               & ~ctl0[ctf_pkg::BIT_BURST_DISABLE]; // RQ1

  // snoop pins
  wire snoop_mode = ctl3[ctf_pkg::BIT_SNOOP_PIN_MODE];
  wire snoop_end = bus_state.transfer_start_strobe & bus_state.last_bus_cycle;
  wire next_snoop_req = bus_state.host_cycle_request & ~snoop_end;

  // bus request follows the snoop copy by one cycle so snoop pin 0 leads it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      snoop_req <= 1'b0;
      bus_request_out <= 1'b0;
    end
    else
    begin
      snoop_req <= next_snoop_req; // RQ22
      bus_request_out <= next_snoop_req & snoop_req; // RQ22
    end
  end

  assign snoop_hi_out = ctl0[ctf_pkg::BIT_SNOOP_CTL_HI]; // RQ2 RQ21
  assign snoop_lo_out = snoop_mode ? snoop_req
                                   : ctl0[ctf_pkg::BIT_SNOOP_CTL_LO]; // RQ2 RQ21
  assign snoop_hi_oe_n = snoop_mode ? bus_state.global_high_z : ~bus_state.bus_owner; // RQ21
  assign snoop_lo_oe_n = snoop_mode ? bus_state.global_high_z : ~bus_state.bus_owner; // RQ2

  // transfer-type pin
  assign transfer_type_out = ~ctl0[ctf_pkg::BIT_TRANSFER_TYPE]; // RQ7
  assign transfer_type_oe_n = ~(bus_state.bus_owner & ~bus_state.bus_mode_one); // RQ7

  // fetch pin, active low
  wire fetch_active = bus_state.fetch_cycle
                      & (~ctl3[ctf_pkg::BIT_FETCH_PIN_MODE] | bus_state.fetch_opcode_phase);
  assign fetch_pin_n = ~fetch_active; // RQ19 RQ20

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_burst_block;
    ctl0[ctf_pkg::BIT_BURST_DISABLE] |-> !cache_burst_request;
  endproperty
  a_burst_block: assert property (p_burst_block) // RQ1
    else $error("burst requested while disabled");

  property p_ctl0_write;
    wr_ctl0 |=> (ctl0 == ($past(pwdata[7:0]) & ctf_pkg::CTL0_WRITE_MASK));
  endproperty
  a_ctl0_write: assert property (p_ctl0_write) // RQ3
    else $error("control zero write lost");

  property p_fifo_parity_follows;
    wr_ctl0 |=> fifo_write_parity == $past(pwdata[ctf_pkg::BIT_FIFO_PARITY]);
  endproperty
  a_fifo_parity_follows: assert property (p_fifo_parity_follows) // RQ3
    else $error("fifo write parity wrong");

  property p_read_parity;
    (in_setup & ~pwrite & hit_ctl0) |=>
      read_data_parity == ((^prdata[7:0]) ^ ~$past(even_mode));
  endproperty
  a_read_parity: assert property (p_read_parity) // RQ4
    else $error("read data parity sense wrong");

  property p_even_invert;
    even_mode |-> (scsi_parity_out != host_parity_in) && (host_parity_out != scsi_parity_in);
  endproperty
  a_even_invert: assert property (p_even_invert) // RQ5
    else $error("even mode not inverting");

  property p_odd_keep;
    !even_mode |-> (scsi_parity_out == host_parity_in)
             && (master_write_parity == ~(^master_write_data));
  endproperty
  a_odd_keep: assert property (p_odd_keep) // RQ6
    else $error("odd mode altered parity");

  property p_tt_mode_one;
    bus_state.bus_mode_one |-> transfer_type_oe_n;
  endproperty
  a_tt_mode_one: assert property (p_tt_mode_one) // RQ7
    else $error("transfer type driven in mode one");

  property p_status_read;
    (in_setup & ~pwrite & hit_status) |=>
      prdata[7:0] == {$past(dma_status.dma_write_direction),
                      $past(dma_status.signal_process_flag), 2'b00, $past(popped_parity),
                      $past(dma_status.true_end_of_process),
                      $past(dma_status.data_request_state),
                      $past(dma_status.data_ack_state_n)};
  endproperty
  a_status_read: assert property (p_status_read) // RQ10
    else $error("status read mismatch");

  property p_signal_process_flag_clear;
    (in_setup & ~pwrite & hit_status) ##1 in_access |-> signal_process_clear;
  endproperty
  a_signal_process_flag_clear: assert property (p_signal_process_flag_clear) // RQ11
    else $error("status read did not clear signal process");

  property p_pop_parity;
    fifo_port_read |=> popped_parity == $past(fifo_bottom_parity);
  endproperty
  a_pop_parity: assert property (p_pop_parity) // RQ12
    else $error("popped parity not latched");

  property p_revision;
    (in_setup & ~pwrite & hit_ctl3) |=> prdata[7:4] == REVISION;
  endproperty
  a_revision: assert property (p_revision) // RQ16
    else $error("revision field wrong");

  property p_clear_self;
    (clear_fifos && clear_fifos_done && !wr_ctl3) |=> !clear_fifos;
  endproperty
  a_clear_self: assert property (p_clear_self) // RQ18
    else $error("clear fifos did not self clear");

  property p_fetch_indirect;
    (ctl3[ctf_pkg::BIT_FETCH_PIN_MODE] && !bus_state.fetch_opcode_phase) |-> fetch_pin_n;
  endproperty
  a_fetch_indirect: assert property (p_fetch_indirect) // RQ19
    else $error("fetch pin active outside opcode");

  property p_fetch_all;
    (!ctl3[ctf_pkg::BIT_FETCH_PIN_MODE] && bus_state.fetch_cycle) |-> !fetch_pin_n;
  endproperty
  a_fetch_all: assert property (p_fetch_all) // RQ20
    else $error("fetch pin missing during fetch");

  property p_snoop_lead;
    (snoop_mode && $rose(bus_request_out)) |-> $past(snoop_lo_out) && snoop_lo_out;
  endproperty
  a_snoop_lead: assert property (p_snoop_lead) // RQ22
    else $error("bus request before snoop copy");

  property p_snoop_end;
    (snoop_end && snoop_mode) |=> !snoop_lo_out ##0 !bus_request_out;
  endproperty
  a_snoop_end: assert property (p_snoop_end) // RQ22
    else $error("snoop copy not negated at last strobe");

  property p_ro_write;
    (wr_done & (hit_flags | hit_status)) |=> $stable(ctl0) && $stable(ctl3);
  endproperty
  a_ro_write: assert property (p_ro_write) // RQ24
    else $error("read-only write changed state");

  property p_burst_allow;
    (bus_state.burst_conditions_met && !ctl0[ctf_pkg::BIT_BURST_DISABLE])
      |-> cache_burst_request;
  endproperty
  a_burst_allow: assert property (p_burst_allow) // RQ1
    else $error("burst not requested while enabled");

  property p_snoop_normal;
    (!snoop_mode && bus_state.bus_owner) |->
      !snoop_hi_oe_n && !snoop_lo_oe_n
      && (snoop_hi_out == ctl0[ctf_pkg::BIT_SNOOP_CTL_HI])
      && (snoop_lo_out == ctl0[ctf_pkg::BIT_SNOOP_CTL_LO]);
  endproperty
  a_snoop_normal: assert property (p_snoop_normal) // RQ2
    else $error("snoop pins wrong during ownership");

  property p_snoop_idle;
    (!snoop_mode && !bus_state.bus_owner) |-> snoop_hi_oe_n && snoop_lo_oe_n;
  endproperty
  a_snoop_idle: assert property (p_snoop_idle) // RQ2
    else $error("snoop pins driven without ownership");

  property p_snoop_alt;
    (snoop_mode && !bus_state.global_high_z) |->
      !snoop_hi_oe_n && !snoop_lo_oe_n && (snoop_lo_out == snoop_req);
  endproperty
  a_snoop_alt: assert property (p_snoop_alt) // RQ21
    else $error("alternate snoop pins not driven");

  property p_snoop_high_z;
    (snoop_mode && bus_state.global_high_z) |-> snoop_hi_oe_n && snoop_lo_oe_n;
  endproperty
  a_snoop_high_z: assert property (p_snoop_high_z) // RQ21
    else $error("snoop pins driven in high impedance mode");

  property p_flags_read;
    (in_setup & ~pwrite & hit_flags) |=>
      prdata[7:0] == {$past(dma_status.lane_empty_flags), $past(dma_status.lane_full_flags)};
  endproperty
  a_flags_read: assert property (p_flags_read) // RQ8 RQ9
    else $error("lane flags read mismatch");

  property p_flush_write;
    wr_ctl3 |=> flush_fifo == $past(pwdata[ctf_pkg::BIT_FLUSH_FIFO]);
  endproperty
  a_flush_write: assert property (p_flush_write) // RQ17
    else $error("flush bit not written");

  property p_unmapped;
    (in_access && !hit_any) |-> pslverr ##1 $stable(ctl0);
  endproperty
  a_unmapped: assert property (p_unmapped) // RQ24
    else $error("unmapped access not refused");

  c_status_read: cover property (rd_done && hit_status);
  c_ctl3_write: cover property (wr_ctl3 ##1 clear_fifos ##[1:8] !clear_fifos);
  c_snoop_burst: cover property (snoop_mode && $rose(bus_request_out) ##[1:20] snoop_end);
  c_unmapped: cover property (pslverr);

endmodule

/* File: sim/ctf_host_model.sv */
`timescale 1ns/10ps
// host side: asks for a host cycle, waits for the bus request, grants the bus
// and runs two transfers, the second flagged as the last one
module ctf_host_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic slow,
  input  wire logic snoop_mode,
  input  wire logic bus_request_out,
  input  wire logic snoop_lo_out,
  output logic      bus_owner,
  output logic      host_cycle_request,
  output logic      strobe,
  output logic      last,
  output logic      done,
  output logic      order_err
);
  logic [2:0] state;
  logic [2:0] cnt;
  logic       prev_bus_req;
  logic       prev_end;

  assign host_cycle_request = (state != 3'd0) && (state != 3'd6);
  assign bus_owner          = (state >= 3'd3) && (state <= 3'd5);
  assign strobe             = (state == 3'd3) || (state == 3'd5);
  assign last               = (state == 3'd5);
  assign done               = (state == 3'd6);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      {state, cnt, prev_bus_req, prev_end, order_err} <= '0;
    end
    else
    begin
      prev_bus_req <= bus_request_out;
      prev_end     <= strobe & last;
      if (snoop_mode && bus_request_out && !prev_bus_req && snoop_lo_out !== 1'b1)
        order_err <= 1'b1;
      if (snoop_mode && prev_end && snoop_lo_out !== 1'b0)
        order_err <= 1'b1;
      cnt <= (state == 3'd2) ? cnt + 3'd1 : 3'd0;
      case (state)
        3'd0: if (start) state <= 3'd1;
        3'd1: if (bus_request_out) state <= 3'd2;
        // grant comes at once or after a few idle cycles
        3'd2: if (cnt == (slow ? 3'd5 : 3'd0)) state <= 3'd3;
        default: state <= (state == 3'd6) ? 3'd0 : state + 3'd1;
      endcase
    end
  end
endmodule

/* File: sim/chip_test_fifo_diag_regs_tb_top.sv */
`timescale 1ns/10ps
module chip_test_fifo_diag_regs_tb_top;
  logic                     core_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [11:0]              paddr = 12'h000;
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]              pwdata = 32'h0, prdata, rd;
  logic                     pready, pslverr, read_data_parity, err, spc_seen;
  ctf_pkg::ctf_dma_status_s dma_status = '0;
  ctf_pkg::ctf_bus_state_s  bus_state;
  logic                     fifo_port_read = 1'b0, fifo_bottom_parity = 1'b0;
  logic                     clear_fifos_done = 1'b0, scsi_parity_in = 1'b0, host_parity_in = 1'b0;
  logic [7:0]               host_data_in = 8'h03, master_write_data = 8'h03, v;
  logic [12:0]              ds;
  logic                     mode_one = 1'b0, ghz = 1'b0, fc = 1'b0, fop = 1'b0, bcm = 1'b0;
  logic                     hm_start = 1'b0, hm_slow = 1'b0, hm_mode = 1'b0;
  logic                     host_parity_out, master_write_parity, scsi_parity_out;
  logic                     host_parity_error, fifo_write_parity, cache_burst_request;
  logic                     snoop_hi_out, snoop_hi_oe_n, snoop_lo_out, snoop_lo_oe_n;
  logic                     bus_request_out, transfer_type_out, transfer_type_oe_n, fetch_pin_n;
  logic                     signal_process_clear, flush_fifo, flush_to_memory, clear_fifos;
  logic                     hm_owner, hm_hcr, hm_strobe, hm_last, hm_done, hm_err;
  logic [3:0]               par_v;
  int                       failures = 0, check_count = 0;

  always #20 core_clk = ~core_clk;
  assign bus_state = {hm_owner, mode_one, hm_hcr, hm_strobe, hm_last, ghz, fc, fop, bcm};
  assign par_v = {host_parity_out, master_write_parity, scsi_parity_out, host_parity_error};

  ctf_chip_test_regs DUT (
    .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .read_data_parity, .dma_status, .bus_state, .fifo_port_read, .fifo_bottom_parity,
    .clear_fifos_done, .scsi_parity_in, .host_data_in, .host_parity_in, .master_write_data,
    .host_parity_out, .master_write_parity, .scsi_parity_out, .host_parity_error,
    .fifo_write_parity, .cache_burst_request, .snoop_hi_out, .snoop_hi_oe_n, .snoop_lo_out,
    .snoop_lo_oe_n, .bus_request_out, .transfer_type_out, .transfer_type_oe_n, .fetch_pin_n,
    .signal_process_clear, .flush_fifo, .flush_to_memory, .clear_fifos
  );

  ctf_host_model host (
    .core_clk, .rst, .start(hm_start), .slow(hm_slow), .snoop_mode(hm_mode),
    .bus_request_out, .snoop_lo_out, .bus_owner(hm_owner), .host_cycle_request(hm_hcr),
    .strobe(hm_strobe), .last(hm_last), .done(hm_done), .order_err(hm_err)
  );

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    spc_seen = signal_process_clear;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
    begin
      failures++;
      conclude();
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle;
    @(negedge core_clk);
  endtask

  task automatic bus_txn(input logic alt, input logic [1:0] sc);
    int n;
    n = 0;
    @(posedge core_clk);
    {hm_start, hm_mode} <= {1'b1, alt};
    @(posedge core_clk);
    hm_start <= 1'b0;
    while (hm_done !== 1'b1 && n < 60)
    begin
      settle();
      n++;
      if (!alt && hm_owner)
        chk({snoop_hi_oe_n, snoop_lo_oe_n, snoop_hi_out, snoop_lo_out}, {2'b00, sc});
      else if (!alt)
        chk({snoop_hi_oe_n, snoop_lo_oe_n}, 2'b11);
      if (alt)
        chk({snoop_hi_oe_n, snoop_lo_oe_n, snoop_hi_out}, {2'b00, sc[1]});
      if (hm_owner)
        chk({transfer_type_oe_n, transfer_type_out}, {mode_one, 1'b1});
    end
    if (hm_done !== 1'b1)
    begin
      failures++;
      conclude();
    end
    // the end-of-burst order check lands one edge after done
    settle();
    chk(hm_err, 1'b0);
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(12'h060, 32'h0);
    chk(err, 1'b0);
    rdchk(12'h06C, {24'h0, ctf_pkg::REVISION_DEFAULT, 4'h0});
    bcm <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 8'hFF : 8'h00;
      apb(1'b1, 12'h060, {24'h0, v});
      rdchk(12'h060, {24'h0, v & ctf_pkg::CTL0_WRITE_MASK});
      settle();
      chk({cache_burst_request, fifo_write_parity}, {!v[7], v[3]});
      chk(transfer_type_out, !v[1]);
    end
    for (int e = 0; e < 2; e++)
    begin
      v = {5'b0, e[0], 2'b0};
      apb(1'b1, 12'h060, {24'h0, v});
      rdchk(12'h060, {24'h0, v});
      host_parity_in <= !e[0];
      settle();
      chk(par_v, {e[0], !e[0], 2'b10});
      chk(read_data_parity, (~^v) ^ e[0]);
      @(posedge core_clk);
      host_parity_in <= e[0];
      settle();
      chk(host_parity_error, 1'b1);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      ds = k ? 13'h0B4A : 13'h14B5;
      dma_status <= ds;
      {fifo_bottom_parity, fifo_port_read} <= {k[0], 1'b1};
      @(posedge core_clk);
      fifo_port_read <= 1'b0;
      apb(1'b1, 12'h064, 32'hFF);
      apb(1'b1, 12'h068, 32'hFF);
      rdchk(12'h064, {24'h0, ds[12:5]});
      chk(spc_seen, 1'b0);
      rdchk(12'h068, {24'h0, ds[4:3], 2'b00, k[0], ds[2:0]});
      chk(spc_seen, 1'b1);
    end
    apb(1'b1, 12'h06C, 32'hFC);
    settle();
    chk({flush_fifo, clear_fifos, flush_to_memory}, 3'b110);
    @(posedge core_clk);
    {dma_status.dma_write_direction, clear_fifos_done} <= 2'b11;
    @(posedge core_clk);
    clear_fifos_done <= 1'b0;
    rdchk(12'h06C, {24'h0, ctf_pkg::REVISION_DEFAULT, 4'h8});
    chk({flush_fifo, clear_fifos, flush_to_memory}, 3'b101);
    apb(1'b1, 12'h06C, 32'h00);
    settle();
    chk(flush_fifo, 1'b0);
    apb(1'b1, 12'h070, 32'hFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h062, 32'h0);
    chk(err, 1'b1);
    rdchk(12'h060, {24'h0, v});
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'h06C, {30'h0, i[2], 1'b0});
      {fc, fop} <= i[1:0];
      settle();
      chk(fetch_pin_n, !(i[1] && (!i[2] || i[0])));
    end
    apb(1'b1, 12'h060, 32'h40);
    bus_txn(1'b0, 2'b10);
    @(posedge core_clk);
    {mode_one, hm_slow} <= 2'b11;
    apb(1'b1, 12'h06C, 32'h01);
    bus_txn(1'b1, 2'b10);
    @(posedge core_clk);
    ghz <= 1'b1;
    settle();
    chk({snoop_hi_oe_n, snoop_lo_oe_n}, 2'b11);
    conclude();
  end
endmodule
